/* csi_cfg.svh */
`ifndef CSI_CFG_SVH
`define CSI_CFG_SVH

// Register selects on the core's data bus port.
`define CSI_SEL_RX       2'h0
`define CSI_SEL_TX       2'h1
`define CSI_SEL_STATUS   2'h2
`define CSI_SEL_CTRL     2'h3

// Control register fields.
`define CSI_VOL_LSB      0
`define CSI_BOOST_BIT    3
`define CSI_RATIO_LSB    8
`define CSI_MUTE_N_BIT   10
`define CSI_GAIN_LSB     11
`define CSI_INSEL_BIT    13
`define CSI_PWR_BIT      14
`define CSI_IRQEN_BIT    15
`define CSI_CTRL_WMASK   16'hff0f
`define CSI_CTRL_RESET   16'h0000

// Status register fields.
`define CSI_ST_UNDER_BIT 0
`define CSI_ST_OVER_BIT  1
`define CSI_ST_TXE_BIT   2
`define CSI_ST_RXF_BIT   3

// Comb ratios.
`define CSI_RATIO_0      8'd125
`define CSI_RATIO_1      8'd128
`define CSI_RATIO_2      8'd105
`define CSI_RATIO_3      8'd81

`endif

/* csi_pkg.sv */
package csi_pkg;
    typedef logic [15:0] csi_word_t;
    typedef enum logic [2:0] {
        CSI_IDLE = 3'b001,
        CSI_RUN  = 3'b010,
        CSI_OFF  = 3'b100
    } csi_state_e;
endpackage

/* csi_fifo.sv */
`timescale 1ns/10ps
module csi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clocking.
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic             flush_i,
    // Fill side.
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } csi_fifo_s;
    csi_fifo_s st_r;
    csi_fifo_s st_nxt;
    logic      push;
    logic      pop;

    assign in_ready_o  = st_r.cnt != (AW+1)'(DEPTH);
    assign out_valid_o = st_r.cnt != '0;
    assign out_data_o  = st_r.mem[st_r.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data_i;
            st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_i) begin
            st_nxt.wp  = '0;
            st_nxt.rp  = '0;
            st_nxt.cnt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end
endmodule

/* csi_sdm.sv */
`timescale 1ns/10ps
module csi_sdm #(
    parameter int WIDTH = 16
) (
    // Clocking.
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic             run_i,
    input  wire logic             tick_i,
    // Sample in, bit out.
    input  wire logic [WIDTH-1:0] sample_i,
    output logic                  bit_o
);
    // Second order error feedback loop on two's complement input.
    typedef struct packed {
        logic [WIDTH+3:0] i1;
        logic [WIDTH+3:0] i2;
        logic             q;
    } csi_sdm_s;
    csi_sdm_s         st_r;
    csi_sdm_s         st_nxt;
    logic [WIDTH+3:0] fb;
    logic [WIDTH+3:0] x;

    assign bit_o = st_r.q;

    always_comb begin
        st_nxt = st_r;
        x  = {{4{sample_i[WIDTH-1]}}, sample_i};
        fb = st_r.q ? (WIDTH+4)'(2**(WIDTH-1)) : -(WIDTH+4)'(2**(WIDTH-1));
        if (!run_i) begin
            st_nxt = '0;
        end else if (tick_i) begin
            st_nxt.i1 = st_r.i1 + x - fb;
            st_nxt.i2 = st_r.i2 + st_nxt.i1 - fb;
            st_nxt.q  = !st_nxt.i2[WIDTH+3];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end
endmodule

/* csi_codec.sv */
// Function
// - Receive sample register is 16-bit read-only, loaded from each decimator output.
// - Loading receive register sets receive-full; reading it clears the flag.
// - With interrupt enable set, receive-full requests the codec interrupt.
// - Transmit sample register is 16-bit write-only; writing clears transmit-empty.
// - With interrupt enable set, transmit-empty requests the codec interrupt.
// - Receive and transmit run in lockstep sharing one interrupt request.
// - All control register bits clear on hardware and software reset.
// - Three low volume bits set attenuation -20 dB to 0 dB in 5 dB steps.
// - Fourth volume bit boosts output by 20 dB.
// - Ratio field bits 8-9 selects 125, 128, 105 or 81.
// - Interpolator gain is ratio/128; decimator gain ratio cubed, power-of-two scaled.
// - Mute bit 10 low silences output; high passes it.
// - One bit selects the analog input, changeable at any time.
// - Third-order comb decimates the modulator bitstream to a 16-bit result.
// - Second-order comb interpolates, then a sigma-delta modulator makes one bit.
// - Reserved bits read zero; software writes zero to them.
// - Input select bit 13 clear picks first input, set picks second.
// - Enable bit 14 clear powers down codec; set wakes it.
// - Interrupt enable is control bit 15.
`timescale 1ns/10ps
`include "csi_cfg.svh"
module csi_codec
    import csi_pkg::*;
#(
    parameter int FIFO_DEPTH = 4,
    parameter int CIC_W      = 24
) (
    // Clocking and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic       sw_rst_i,
    // Core data bus port.
    input  wire logic       sel_i,
    input  wire logic       rd_i,
    input  wire logic       wr_i,
    input  wire logic [1:0] addr_i,
    input  wire logic [15:0] wdata_i,
    output logic [15:0]     rdata_o,
    output logic            tx_ready_o,
    // Converter side.
    input  wire logic       mod_tick_i,
    input  wire logic       adc_bit_i,
    output logic            dac_bit_o,
    output logic [3:0]      volume_level_o,
    output logic            output_silence_n_o,
    output logic [1:0]      mic_gain_o,
    output logic            input_source_select_o,
    output logic            codec_power_enable_o,
    // Interrupt.
    output logic            irq_o
);
    localparam int RW = 8;

    typedef struct packed {
        logic [2:0]        adc_sync;
        logic              tick_d;
        logic [15:0]       ctrl;
        csi_word_t         rx;
        logic              rxf;
        logic              txe;
        logic              under;
        logic              over;
        logic              under_seen;
        logic              over_seen;
        csi_word_t         dac_hold;
        logic [RW-1:0]     phase;
        logic [CIC_W-1:0]  ai1;
        logic [CIC_W-1:0]  ai2;
        logic [CIC_W-1:0]  ai3;
        logic [CIC_W-1:0]  ad1;
        logic [CIC_W-1:0]  ad2;
        logic [CIC_W-1:0]  ac1;
        logic [CIC_W-1:0]  ac2;
        logic [CIC_W-1:0]  ac3;
        logic [CIC_W-1:0]  dc1;
        logic [CIC_W-1:0]  di1;
        logic [CIC_W-1:0]  di2;
        logic              fifo_rd;
        csi_word_t         rdata;
        logic              irq;
        logic              fifo_rdy;
        csi_state_e        state;
    } csi_st_s;

    csi_st_s          st_r;
    csi_st_s          st_nxt;
    logic [RW-1:0]    ratio;
    logic             frame;
    logic             fifo_in_rdy;
    logic             fifo_out_vld;
    csi_word_t        fifo_out;
    logic             bus_wr_tx;
    logic [CIC_W-1:0] adc_step;
    logic [CIC_W-1:0] c1;
    logic [CIC_W-1:0] c2;
    logic [CIC_W-1:0] c3;
    logic [CIC_W-1:0] dc;
    logic [CIC_W-1:0] dd;
    logic [CIC_W+RW-1:0] scaled;
    csi_word_t        dac_word;
    logic             tick;
    logic             pwr;

    assign pwr       = st_r.ctrl[`CSI_PWR_BIT];
    assign tick      = st_r.tick_d;
    assign bus_wr_tx = sel_i && wr_i && addr_i == `CSI_SEL_TX;

    // Writes are taken into the FIFO while space remains; tx_ready_o tells the core to wait.
    csi_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .flush_i     (!pwr || sw_rst_i),
        .in_valid_i  (bus_wr_tx),
        .in_ready_o  (fifo_in_rdy),
        .in_data_i   (wdata_i),
        .out_valid_o (fifo_out_vld),
        .out_ready_i (st_r.fifo_rd),
        .out_data_o  (fifo_out)
    );

    csi_sdm #(
        .WIDTH (16)
    ) u_sdm (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .ce_i     (ce_i),
        .run_i    (pwr),
        .tick_i   (tick),
        .sample_i (dac_word),
        .bit_o    (dac_bit_o)
    );

    always_comb begin
        case (st_r.ctrl[`CSI_RATIO_LSB +: 2])
            2'h0:    ratio = `CSI_RATIO_0;
            2'h1:    ratio = `CSI_RATIO_1;
            2'h2:    ratio = `CSI_RATIO_2;
            default: ratio = `CSI_RATIO_3;
        endcase
    end

    assign frame = tick && (st_r.phase == ratio - 8'd1);
    // Bitstream maps to +1/-1 so the comb output is signed two's complement.
    assign adc_step = st_r.adc_sync[2] ? CIC_W'(1) : {CIC_W{1'b1}};
    assign c1       = st_r.ai3 - st_r.ad1;
    assign c2       = c1 - st_r.ad2;
    assign c3       = c2 - st_r.ac3;
    assign dc       = {{(CIC_W-16){st_r.dac_hold[15]}}, st_r.dac_hold} - st_r.dc1;
    assign dd       = dc - st_r.di1;
    // Interpolator gain is ratio/128 after the divide by 128 below.
    assign scaled   = {{RW{st_r.di2[CIC_W-1]}}, st_r.di2};
    assign dac_word = scaled[22:7];

    always_comb begin
        st_nxt = st_r;
        st_nxt.adc_sync = {st_r.adc_sync[1:0], adc_bit_i};
        st_nxt.tick_d   = mod_tick_i;
        st_nxt.fifo_rd  = 1'b0;
        st_nxt.fifo_rdy = fifo_in_rdy;
        // Control register write; reserved bits 4-7 are never stored.
        if (sel_i && wr_i && addr_i == `CSI_SEL_CTRL) begin
            st_nxt.ctrl = wdata_i & `CSI_CTRL_WMASK;
        end
        if (bus_wr_tx) begin
            st_nxt.txe = 1'b0;
            if (st_r.under_seen) begin
                st_nxt.under      = 1'b0;
                st_nxt.under_seen = 1'b0;
            end
        end
        if (sel_i && rd_i && addr_i == `CSI_SEL_STATUS) begin
            st_nxt.under_seen = st_r.under;
            st_nxt.over_seen  = st_r.over;
        end
        if (sel_i && rd_i && addr_i == `CSI_SEL_RX) begin
            st_nxt.rxf = 1'b0;
            if (st_r.over_seen) begin
                st_nxt.over      = 1'b0;
                st_nxt.over_seen = 1'b0;
            end
        end
        // Read data register.
        if (sel_i && rd_i && addr_i == `CSI_SEL_RX) begin
            st_nxt.rdata = st_r.rx;
        end else if (sel_i && rd_i && addr_i == `CSI_SEL_STATUS) begin
            st_nxt.rdata = {12'h000, st_r.rxf, st_r.txe, st_r.over, st_r.under};
        end else if (sel_i && rd_i && addr_i == `CSI_SEL_CTRL) begin
            st_nxt.rdata = st_r.ctrl;
        end else begin
            st_nxt.rdata = 16'h0000;
        end
        case (st_r.state)
            CSI_IDLE: begin
                st_nxt.state = pwr ? CSI_RUN : CSI_OFF;
            end
            CSI_RUN: begin
                if (tick) begin
                    // Three integrators at the modulator rate.
                    st_nxt.ai1 = st_r.ai1 + adc_step;
                    st_nxt.ai2 = st_r.ai2 + st_r.ai1;
                    st_nxt.ai3 = st_r.ai3 + st_r.ai2;
                    // Two integrators rebuild the held sample at the high rate.
                    st_nxt.di1 = st_r.di1 + st_r.dc1;
                    st_nxt.di2 = st_r.di2 + st_r.di1;
                    st_nxt.phase = frame ? '0 : st_r.phase + 8'd1;
                end
                if (frame) begin
                    st_nxt.ad1 = st_r.ai3;
                    st_nxt.ad2 = c1;
                    st_nxt.ac3 = c2;
                    st_nxt.rx  = c3[CIC_W-1 -: 16];
                    st_nxt.rxf = 1'b1;
                    st_nxt.over = st_r.over || st_r.rxf;
                    // Second order differentiator at the low rate feeds the integrators.
                    st_nxt.dc1 = dd;
                    st_nxt.di1 = st_r.di1 + dd;
                    if (fifo_out_vld) begin
                        st_nxt.dac_hold = fifo_out;
                        st_nxt.fifo_rd  = 1'b1;
                        st_nxt.txe      = 1'b1;
                    end else begin
                        st_nxt.under = 1'b1;
                        st_nxt.txe   = 1'b1;
                    end
                end
                if (!pwr) begin
                    st_nxt.state = CSI_OFF;
                end
            end
            CSI_OFF: begin
                st_nxt.phase = '0;
                st_nxt.ai1 = '0;
                st_nxt.ai2 = '0;
                st_nxt.ai3 = '0;
                st_nxt.ad1 = '0;
                st_nxt.ad2 = '0;
                st_nxt.ac3 = '0;
                st_nxt.di1 = '0;
                st_nxt.di2 = '0;
                st_nxt.dc1 = '0;
                st_nxt.rxf = 1'b0;
                st_nxt.txe = 1'b1;
                if (pwr) begin
                    st_nxt.state = CSI_RUN;
                end
            end
            default: begin
                st_nxt.state = CSI_IDLE;
            end
        endcase
        st_nxt.irq = st_nxt.ctrl[`CSI_IRQEN_BIT] && (st_nxt.rxf || st_nxt.txe);
        if (sw_rst_i) begin
            st_nxt.ctrl  = `CSI_CTRL_RESET;
            st_nxt.rxf   = 1'b0;
            st_nxt.txe   = 1'b1;
            st_nxt.under = 1'b0;
            st_nxt.over  = 1'b0;
            st_nxt.irq   = 1'b0;
            st_nxt.state = CSI_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_r       <= '0;
            st_r.ctrl  <= `CSI_CTRL_RESET;
            st_r.txe   <= 1'b1;
            st_r.state <= CSI_OFF;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // Analog trims are wired straight from the control register flops.
    assign volume_level_o        = st_r.ctrl[`CSI_VOL_LSB +: 4];
    assign output_silence_n_o    = st_r.ctrl[`CSI_MUTE_N_BIT];
    assign mic_gain_o            = st_r.ctrl[`CSI_GAIN_LSB +: 2];
    assign input_source_select_o = st_r.ctrl[`CSI_INSEL_BIT];
    assign codec_power_enable_o  = pwr;
    assign rdata_o               = st_r.rdata;
    assign irq_o                 = st_r.irq;
    assign tx_ready_o            = st_r.fifo_rdy;
endmodule

/* csi_codec_checker.sv */
`timescale 1ns/10ps
`include "csi_cfg.svh"
module csi_codec_checker #(
    parameter int FIFO_DEPTH = 4,
    parameter int CIC_W      = 24
) (
    // Clocking.
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        ce_i,
    input wire logic        sw_rst_i,
    // Bus.
    input wire logic        sel_i,
    input wire logic        rd_i,
    input wire logic        wr_i,
    input wire logic [1:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] rdata_o,
    input wire logic        tx_ready_o,
    // Converter side.
    input wire logic        mod_tick_i,
    input wire logic        adc_bit_i,
    input wire logic        dac_bit_o,
    input wire logic [3:0]  volume_level_o,
    input wire logic        output_silence_n_o,
    input wire logic [1:0]  mic_gain_o,
    input wire logic        input_source_select_o,
    input wire logic        codec_power_enable_o,
    input wire logic        irq_o
);
    logic       irqen_r;
    logic       acc;
    logic       rd_rx;
    logic       rd_st;
    logic       rd_ct;
    logic       wr_ct;
    logic       wr_tx;
    logic [4:0] ctl_w;
    assign acc   = ce_i && sel_i && !sw_rst_i;
    assign rd_rx = acc && rd_i && addr_i == `CSI_SEL_RX;
    assign rd_st = acc && rd_i && addr_i == `CSI_SEL_STATUS;
    assign rd_ct = acc && rd_i && addr_i == `CSI_SEL_CTRL;
    assign wr_ct = acc && wr_i && addr_i == `CSI_SEL_CTRL;
    assign wr_tx = acc && wr_i && addr_i == `CSI_SEL_TX && tx_ready_o;
    assign ctl_w = {codec_power_enable_o, input_source_select_o, mic_gain_o, output_silence_n_o};
    // The interrupt enable bit is not a port, so it is mirrored from the writes.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || (ce_i && sw_rst_i)) begin
            irqen_r <= 1'h0;
        end else if (wr_ct) begin
            irqen_r <= wdata_i[`CSI_IRQEN_BIT];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Frames land only near a tick, so a quiet stretch keeps a flag from being set again.
    sequence s_quiet;
        !mod_tick_i [*4];
    endsequence
    sequence s_rx_poll;
        (s_quiet ##0 rd_rx) ##2 (rd_st && !mod_tick_i);
    endsequence
    sequence s_tx_poll;
        (s_quiet ##0 wr_tx) ##2 (rd_st && !mod_tick_i);
    endsequence
    AST_HW_RESET: assert property (disable iff (1'h0) !rst_n_i |=> ctl_w == 5'h00 &&
        volume_level_o == 4'h0 && rdata_o == 16'h0000 && !irq_o && !dac_bit_o)
        else $error("outputs not cleared by hardware reset");
    AST_SW_RESET: assert property (ce_i && sw_rst_i |=> ctl_w == 5'h00 &&
        volume_level_o == 4'h0) else $error("controls not cleared by software reset");
    AST_CTRL_WRITE: assert property (wr_ct |=> ctl_w == $past(wdata_i[14:10]) &&
        volume_level_o == $past(wdata_i[3:0])) else $error("control outputs differ from write");
    AST_CTRL_READ: assert property (rd_ct |=> rdata_o[15:10] == {$past(irqen_r), $past(ctl_w)} &&
        rdata_o[7:0] == {4'h0, $past(volume_level_o)}) else $error("control read back wrong");
    AST_STAT_RSVD: assert property (rd_st |=> rdata_o[15:4] == 12'h000)
        else $error("status reserved bits not zero");
    AST_IDLE_ZERO: assert property (ce_i && !(sel_i && rd_i) |=> rdata_o == 16'h0000)
        else $error("read data not zero outside a read");
    AST_RX_CLEAR: assert property (s_rx_poll |=> !rdata_o[`CSI_ST_RXF_BIT])
        else $error("receive-full not cleared by sample read");
    AST_TX_CLEAR: assert property (s_tx_poll |=> !rdata_o[`CSI_ST_TXE_BIT])
        else $error("transmit-empty not cleared by sample write");
    AST_IRQ_OFF: assert property (!irqen_r && !$past(irqen_r) |-> !irq_o)
        else $error("interrupt raised while disabled");
    AST_IRQ_ON: assert property (rd_st ##1 (rdata_o[3:2] != 2'h0 && irqen_r &&
        $past(irqen_r) && !sw_rst_i) |-> ##[0:1] irq_o) else $error("interrupt missing with flag set");
endmodule

bind csi_codec csi_codec_checker #(.FIFO_DEPTH(FIFO_DEPTH), .CIC_W(CIC_W)) u_csi_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .sw_rst_i(sw_rst_i), .sel_i(sel_i),
    .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .tx_ready_o(tx_ready_o), .mod_tick_i(mod_tick_i), .adc_bit_i(adc_bit_i),
    .dac_bit_o(dac_bit_o), .volume_level_o(volume_level_o),
    .output_silence_n_o(output_silence_n_o), .mic_gain_o(mic_gain_o),
    .input_source_select_o(input_source_select_o),
    .codec_power_enable_o(codec_power_enable_o), .irq_o(irq_o)
);

/* csi_core_model.sv */
`timescale 1ns/10ps
`include "csi_cfg.svh"
module csi_core_model (
    // Clock and test mode.
    input  wire logic        clk_i,
    input  wire logic        raw_i,
    // Requests toward the codec.
    output logic             sel_o,
    output logic             rd_o,
    output logic             wr_o,
    output logic [1:0]       addr_o,
    output logic [15:0]      wdata_o,
    // Answer.
    input  wire logic [15:0] rdata_i
);
    initial begin
        sel_o   = 1'h0;
        rd_o    = 1'h0;
        wr_o    = 1'h0;
        addr_o  = 2'h0;
        wdata_o = 16'h0000;
    end
    // Lines are inverted after the strobe so a stale value never looks valid.
    task automatic access(input logic w, input logic [1:0] a, input logic [15:0] d,
                          output logic [15:0] q);
        sel_o   <= 1'h1;
        rd_o    <= !w;
        wr_o    <= w;
        addr_o  <= a;
        wdata_o <= (a == `CSI_SEL_CTRL && !raw_i) ? (d & `CSI_CTRL_WMASK) : d;
        @(posedge clk_i);
        sel_o   <= 1'h0;
        rd_o    <= 1'h0;
        wr_o    <= 1'h0;
        addr_o  <= ~a;
        wdata_o <= ~d;
        // Read data is taken mid-cycle, away from the edge that launches it.
        @(negedge clk_i);
        q = rdata_i;
        @(posedge clk_i);
    endtask
endmodule

/* csi_codec_tb_top.sv */
`timescale 1ns/10ps
`include "csi_cfg.svh"
module csi_codec_tb_top
    import csi_pkg::*;
;
    localparam int LIMIT = 60000;
    logic       clk_i, rst_n_i, sw_rst_i, mod_tick_i, adc_bit_i, raw, sel, rd, wr;
    logic       tx_ready_o, dac_bit_o, output_silence_n_o, input_source_select_o;
    logic       codec_power_enable_o, irq_o;
    logic [1:0] addr, mic_gain_o, dac_seen;
    logic [2:0] phase;
    logic [3:0] volume_level_o;
    logic [4:0] ctl_seen;
    csi_word_t  wdata, rdata_o, q, v, st;
    int         ticks, tk, t0, cyc, seed, bad_count, num_checks;
    assign ctl_seen = {codec_power_enable_o, input_source_select_o, mic_gain_o, output_silence_n_o};
    csi_codec dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'h1), .sw_rst_i(sw_rst_i),
        .sel_i(sel), .rd_i(rd), .wr_i(wr), .addr_i(addr), .wdata_i(wdata),
        .rdata_o(rdata_o), .tx_ready_o(tx_ready_o), .mod_tick_i(mod_tick_i),
        .adc_bit_i(adc_bit_i), .dac_bit_o(dac_bit_o), .volume_level_o(volume_level_o),
        .output_silence_n_o(output_silence_n_o), .mic_gain_o(mic_gain_o),
        .input_source_select_o(input_source_select_o),
        .codec_power_enable_o(codec_power_enable_o), .irq_o(irq_o)
    );
    csi_core_model core (
        .clk_i(clk_i), .raw_i(raw), .sel_o(sel), .rd_o(rd), .wr_o(wr),
        .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata_o)
    );
    task automatic check(input csi_word_t seen, input csi_word_t exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    function automatic int ratio_of(input int c);
        case (c)
            0: return int'(`CSI_RATIO_0);
            1: return int'(`CSI_RATIO_1);
            2: return int'(`CSI_RATIO_2);
            default: return int'(`CSI_RATIO_3);
        endcase
    endfunction
    task automatic bus(input logic w, input logic [1:0] a, input csi_word_t d);
        core.access(w, a, d, q);
    endtask
    // Polls until a frame lands, notes the tick count, then takes the sample.
    task automatic wait_rx();
        int n;
        n = 0;
        q = 16'h0000;
        while (!q[`CSI_ST_RXF_BIT] && n < 1500) begin
            bus(1'h0, `CSI_SEL_STATUS, 16'h0000);
            n++;
        end
        tk = ticks;
        st = q;
        check({15'h0000, q[`CSI_ST_RXF_BIT]}, 16'h0001);
        bus(1'h0, `CSI_SEL_RX, 16'h0000);
    endtask
    initial begin
        clk_i = 1'h0;
        forever #20 clk_i = ~clk_i;
    end
    // Ticks every eight cycles keep frames far apart relative to bus accesses.
    always @(posedge clk_i) begin
        phase      <= phase + 3'h1;
        mod_tick_i <= (phase == 3'h7);
        adc_bit_i  <= 1'($random(seed));
        ticks      <= ticks + int'(mod_tick_i);
        cyc        <= cyc + 1;
        if (codec_power_enable_o) begin
            dac_seen <= dac_seen | (dac_bit_o ? 2'h2 : 2'h1);
        end
        if (cyc == LIMIT) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        seed = 77;
        {bad_count, num_checks, cyc, ticks} = '0;
        {phase, dac_seen, raw, sw_rst_i, mod_tick_i, adc_bit_i, rst_n_i} = '0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'h1;
        @(posedge clk_i);
        bus(1'h0, `CSI_SEL_CTRL, 16'h0000);
        check(q, `CSI_CTRL_RESET);
        bus(1'h0, `CSI_SEL_STATUS, 16'h0000);
        check(q, 16'h0004);
        bus(1'h0, `CSI_SEL_TX, 16'h0000);
        check(q, 16'h0000);
        raw <= 1'h1;
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 16'hffff : (i == 1) ? 16'h00f0 : 16'($random(seed));
            bus(1'h1, `CSI_SEL_CTRL, v);
            bus(1'h0, `CSI_SEL_CTRL, 16'h0000);
            check(q, v & `CSI_CTRL_WMASK);
            check({12'h000, volume_level_o}, {12'h000, v[3:0]});
            check({11'h000, ctl_seen}, {11'h000, v[14:10]});
        end
        sw_rst_i <= 1'h1;
        @(posedge clk_i);
        sw_rst_i <= 1'h0;
        bus(1'h0, `CSI_SEL_CTRL, 16'h0000);
        check(q | {11'h000, ctl_seen}, 16'h0000);
        raw <= 1'h0;
        for (int c = 0; c < 4; c++) begin
            bus(1'h1, `CSI_SEL_CTRL, 16'h4400 | 16'(c << `CSI_RATIO_LSB));
            wait_rx();
            wait_rx();
            t0 = tk;
            wait_rx();
            check(16'(tk - t0), 16'(ratio_of(c)));
            check({15'h0000, irq_o}, 16'h0000);
        end
        // The fifth word meets a full queue and must vanish, so the underrun comes one frame early.
        bus(1'h1, `CSI_SEL_CTRL, 16'hc500);
        wait_rx();
        for (int i = 0; i < 5; i++) begin
            if (i == 4) begin
                bus(1'h0, `CSI_SEL_STATUS, 16'h0000);
                check(q & 16'h0004, 16'h0000);
                @(posedge clk_i);
                check({15'h0000, tx_ready_o}, 16'h0000);
            end
            bus(1'h1, `CSI_SEL_TX, 16'($random(seed)));
        end
        bus(1'h0, `CSI_SEL_STATUS, 16'h0000);
        check(q & 16'h0004, 16'h0000);
        check({15'h0000, irq_o}, 16'h0000);
        for (int f = 1; f < 6; f++) begin
            wait_rx();
            check(st & 16'h000d, (f == 5) ? 16'h000d : 16'h000c);
            check({15'h0000, irq_o}, 16'h0001);
            if (f == 1) begin
                check({15'h0000, tx_ready_o}, 16'h0001);
            end
        end
        check({14'h0000, dac_seen}, 16'h0003);
        complete_run();
    end
endmodule
